// *** hdl/smc_pkg.sv ***
/*
  Constants for the standby mode controller: control register layout,
  register offsets on the plain register port, settling counts and states.
  Assumes it is compiled before every file that names it.
*/
package smc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] SMC_ADDR_SYSCTRL = 4'h0;
  localparam logic [3:0] SMC_ADDR_STATUS = 4'h1;
  localparam logic [3:0] SMC_ADDR_INTEN = 4'h2;
  localparam logic [7:0] SMC_SYSCTRL_RESET = 8'h09;
  localparam int SMC_BIT_SSB = 7;
  localparam int SMC_BIT_STS_HI = 6;
  localparam int SMC_BIT_STS_LO = 4;
  localparam int SMC_BIT_XRST = 3;
  localparam int SMC_BIT_NONMASKABLE_EDGE_SELECT = 2;
  localparam int SMC_BIT_HIE = 1;
  localparam int SMC_BIT_RAM_ENABLE_BIT = 0;
  localparam logic [7:0] SMC_INTEN_RESET = 8'h00;
  // ****************************************************************
  // Settling counts in oscillator clock states
  // ****************************************************************
  localparam logic [17:0] SMC_SETTLE_0 = 18'h02000;
  localparam logic [17:0] SMC_SETTLE_1 = 18'h04000;
  localparam logic [17:0] SMC_SETTLE_2 = 18'h08000;
  localparam logic [17:0] SMC_SETTLE_3 = 18'h10000;
  localparam logic [17:0] SMC_SETTLE_4 = 18'h20000;
  localparam logic [17:0] SMC_SETTLE_5 = 18'h00400;
  localparam int SMC_CNT_W = 18;
  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    SMC_RUN,
    SMC_SW_HW_STANDBY_PIN_N,
    SMC_SETTLE,
    SMC_RES_HOLD,
    SMC_HW_HW_STANDBY_PIN_N,
    SMC_HW_WAIT
  } smc_state_t;
endpackage

// *** hdl/smc_settle_if.sv ***
/*
  Interface between the sequencer and its settling counter.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface smc_settle_if;
  logic start;
  logic [2:0] sel;
  logic done;
  modport ctrl (output start, output sel, input done);
  modport cnt (input start, input sel, output done);
endinterface
`default_nettype wire

// *** hdl/smc_settle_counter.sv ***
/*
  Settling counter, counting oscillator states after a restart.
  Assumes it is clocked by the restarted oscillator and enabled by ce_in.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_settle_counter (
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Sequencer side
  smc_settle_if.cnt sif
);
  logic [smc_pkg::SMC_CNT_W-1:0] cnt_q;
  logic [smc_pkg::SMC_CNT_W-1:0] target_q;
  logic busy_q;

  function automatic logic [smc_pkg::SMC_CNT_W-1:0] settle_count(input logic [2:0] sel);
    case (sel)
      3'h0: settle_count = smc_pkg::SMC_SETTLE_0;
      3'h1: settle_count = smc_pkg::SMC_SETTLE_1;
      3'h2: settle_count = smc_pkg::SMC_SETTLE_2;
      3'h3: settle_count = smc_pkg::SMC_SETTLE_3;
      3'h5: settle_count = smc_pkg::SMC_SETTLE_5;
      default: settle_count = smc_pkg::SMC_SETTLE_4;
    endcase
  endfunction

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      target_q <= '0;
      busy_q <= 1'b0;
      sif.done <= 1'b0;
    end else if (ce_in) begin
      sif.done <= 1'b0;
      if (sif.start) begin
        target_q <= settle_count(sif.sel);
        cnt_q <= 18'h00001;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == target_q) begin
          busy_q <= 1'b0;
          sif.done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 18'h00001;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/smc_top.sv ***
/*
  Standby mode controller: software standby entry and wake, hardware
  standby entry and recovery, and the system control register.
  Assumes synchronous pin inputs, a halt pulse from the CPU, and that the
  oscillator clock drives clk_in while the gated system clock is clk_en_out.
*/
// The implementer's own choices: the strobed register port and the placing of the registers.
// How it works
// - Halt with standby select set enters software standby.
// - Software standby stops system clock, halts CPU and peripherals.
// - Entering software standby resets peripherals; CPU and RAM kept.
// - Software standby left only by reset, standby pin, qualifying interrupt.
// - Qualifying interrupt restarts oscillator, waits settling, then interrupt handling.
// - Reset low in standby restarts oscillator; rising reset starts reset handling.
// - Standby pin low in software standby goes to hardware standby.
// - Settling select codes 000 to 100 give 8192 to 131072 states.
// - Any select accepted; code 101 gives 1024 states.
// - Edge select bit picks falling (0) or rising (1) wake edge.
// - Ports hold their output states during software standby.
// - Standby pin low from any state enters hardware standby.
// - Hardware standby halts all, resets peripherals, floats ports; RAM kept.
// - Standby pin high restarts oscillator; rising reset resumes execution.
// - Standby select stays set after interrupt wake until software clears.
// - Standby select is bit 7; settling select is bits 6 to 4.
`timescale 1ns/1ps
`default_nettype none
module smc_top (
  // Clock, reset and enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Register port
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // CPU and pins
  input wire logic cpu_halt_in,
  input wire logic reset_pin_n_in,
  input wire logic hw_standby_pin_n_in,
  input wire logic nmi_pin_n_in,
  input wire logic [7:0] irq_in,
  input wire logic [15:0] key_input_lines_in,
  // Power control outputs
  output logic clk_en_out,
  output logic cpu_halt_out,
  output logic periph_reset_out,
  output logic cpu_reset_out,
  output logic port_hold_out,
  output logic port_float_out,
  output logic int_start_out,
  output logic osc_run_out
);
  // Lines that may wake the chip; line 6 also gathers the key inputs.
  localparam logic [7:0] QUAL_LINES = 8'h47;
  localparam int KEY_LINE = 6;
  smc_pkg::smc_state_t state_q;
  logic [7:0] sysctrl_q;
  logic [7:0] inten_q;
  logic nmi_prev_q;
  logic res_prev_q;
  logic wake_int;
  logic nmi_edge;
  logic any_int;
  logic [7:0] status_word;
  logic [7:0] line_req;
  logic key_low;
  logic wr_ok;
  smc_settle_if sif ();

  smc_settle_counter u_settle (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .sif(sif)
  );

  // ****************************************************************
  // State decodes
  // ****************************************************************
  // Both hardware standby states float the ports and hold the registers in reset.
  function automatic logic in_hw_standby(input smc_pkg::smc_state_t st);
    in_hw_standby = (st == smc_pkg::SMC_HW_HW_STANDBY_PIN_N) || (st == smc_pkg::SMC_HW_WAIT);
  endfunction

  // Settling still counts as software standby: ports hold until the clock returns.
  function automatic logic in_sw_standby(input smc_pkg::smc_state_t st);
    in_sw_standby = (st == smc_pkg::SMC_SW_HW_STANDBY_PIN_N) || (st == smc_pkg::SMC_SETTLE);
  endfunction

  // The CPU stays in reset until the reset pin rises, from either kind of standby.
  function automatic logic holds_cpu_reset(input smc_pkg::smc_state_t st);
    holds_cpu_reset = (st == smc_pkg::SMC_RES_HOLD) || in_hw_standby(st);
  endfunction

  // ****************************************************************
  // Wake detection
  // ****************************************************************
  // selected nmi edge
  assign nmi_edge = sysctrl_q[smc_pkg::SMC_BIT_NONMASKABLE_EDGE_SELECT] ? (!nmi_prev_q && nmi_pin_n_in)
                                                       : (nmi_prev_q && !nmi_pin_n_in);
  // qualifying lines only
  // Lines 3, 4, 5 and 7 never wake the chip, whatever their enables say, so a
  // forgotten enable costs power but cannot cause a false wake.
  assign key_low = !(&key_input_lines_in);
  for (genvar i = 0; i < 8; i++) begin : g_line
    if (i == KEY_LINE) begin : g_key
      assign line_req[i] = inten_q[i] & (irq_in[i] | key_low);
    end else if (QUAL_LINES[i]) begin : g_irq
      assign line_req[i] = inten_q[i] & irq_in[i];
    end else begin : g_off
      assign line_req[i] = 1'b0;
    end
  end
  assign any_int = |line_req;
  assign wake_int = nmi_edge | any_int;
  assign sif.sel = sysctrl_q[smc_pkg::SMC_BIT_STS_HI:smc_pkg::SMC_BIT_STS_LO];
  assign sif.start = ce_in && (state_q == smc_pkg::SMC_SW_HW_STANDBY_PIN_N) && hw_standby_pin_n_in
                     && reset_pin_n_in && wake_int;
  assign status_word = {5'h00, 3'(state_q)};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      nmi_prev_q <= 1'b1;
      res_prev_q <= 1'b1;
    end else if (ce_in) begin
      nmi_prev_q <= nmi_pin_n_in;
      res_prev_q <= reset_pin_n_in;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= smc_pkg::SMC_RUN;
    end else if (ce_in) begin
      if (!hw_standby_pin_n_in) begin
        state_q <= smc_pkg::SMC_HW_HW_STANDBY_PIN_N;
      end else begin
        case (state_q)
          smc_pkg::SMC_RUN: begin
            if (cpu_halt_in && sysctrl_q[smc_pkg::SMC_BIT_SSB]) begin
              state_q <= smc_pkg::SMC_SW_HW_STANDBY_PIN_N;
            end
          end
          smc_pkg::SMC_SW_HW_STANDBY_PIN_N: begin
            if (!reset_pin_n_in) begin
              state_q <= smc_pkg::SMC_RES_HOLD;
            end else if (wake_int) begin
              state_q <= smc_pkg::SMC_SETTLE;
            end
          end
          smc_pkg::SMC_SETTLE: begin
            if (!reset_pin_n_in) begin
              state_q <= smc_pkg::SMC_RES_HOLD;
            end else if (sif.done) begin
              state_q <= smc_pkg::SMC_RUN;
            end
          end
          smc_pkg::SMC_RES_HOLD: begin
            if (reset_pin_n_in && !res_prev_q) begin
              state_q <= smc_pkg::SMC_RUN;
            end
          end
          smc_pkg::SMC_HW_HW_STANDBY_PIN_N: begin
            state_q <= smc_pkg::SMC_HW_WAIT;
          end
          smc_pkg::SMC_HW_WAIT: begin
            if (reset_pin_n_in && !res_prev_q) begin
              state_q <= smc_pkg::SMC_RUN;
            end
          end
          default: begin
            state_q <= smc_pkg::SMC_RUN;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Writes are taken only while running; the CPU cannot issue them otherwise.
  assign wr_ok = reg_wr_in && (state_q == smc_pkg::SMC_RUN);

  // Software standby leaves both registers alone, so the select bits survive a wake;
  // only hardware standby returns them to their initial values.
  // reset registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sysctrl_q <= smc_pkg::SMC_SYSCTRL_RESET;
    end else if (ce_in) begin
      if (in_hw_standby(state_q)) begin
        sysctrl_q <= smc_pkg::SMC_SYSCTRL_RESET;
      end else if (wr_ok && reg_addr_in == smc_pkg::SMC_ADDR_SYSCTRL) begin
        // The reset-status bit is read-only and keeps its value.
        sysctrl_q <= {reg_wdata_in[7:4], sysctrl_q[smc_pkg::SMC_BIT_XRST],
                      reg_wdata_in[2:0]};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      inten_q <= smc_pkg::SMC_INTEN_RESET;
    end else if (ce_in) begin
      if (in_hw_standby(state_q)) begin
        inten_q <= smc_pkg::SMC_INTEN_RESET;
      end else if (wr_ok && reg_addr_in == smc_pkg::SMC_ADDR_INTEN) begin
        inten_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in) begin
      reg_rdata_out <= 8'h00;
      if (reg_rd_in) begin
        case (reg_addr_in)
          smc_pkg::SMC_ADDR_SYSCTRL: reg_rdata_out <= sysctrl_q;
          smc_pkg::SMC_ADDR_STATUS: reg_rdata_out <= status_word;
          smc_pkg::SMC_ADDR_INTEN: reg_rdata_out <= inten_q;
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************************************
  // Power outputs
  // ****************************************************************
  // Every output is registered from the state (int_start_out also from sif.done and pins, osc_run_out from the standby pin), so each lags by one
  // cycle; the sequencer never reads its own outputs back.
  // clock stopped, all halted
  // clock gated on at count end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      clk_en_out <= 1'b1;
      cpu_halt_out <= 1'b0;
    end else if (ce_in) begin
      clk_en_out <= (state_q == smc_pkg::SMC_RUN);
      cpu_halt_out <= (state_q != smc_pkg::SMC_RUN);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      periph_reset_out <= 1'b0;
      cpu_reset_out <= 1'b0;
    end else if (ce_in) begin
      periph_reset_out <= (state_q != smc_pkg::SMC_RUN);
      cpu_reset_out <= holds_cpu_reset(state_q);
    end
  end

  // Ports hold or float, never both: the two kinds of standby use disjoint states.
  // ports hold
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      port_hold_out <= 1'b0;
      port_float_out <= 1'b0;
    end else if (ce_in) begin
      port_hold_out <= in_sw_standby(state_q);
      port_float_out <= in_hw_standby(state_q);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      int_start_out <= 1'b0;
      osc_run_out <= 1'b1;
    end else if (ce_in) begin
      int_start_out <= (state_q == smc_pkg::SMC_SETTLE) && sif.done && reset_pin_n_in &&
                       hw_standby_pin_n_in;
      osc_run_out <= (state_q != smc_pkg::SMC_SW_HW_STANDBY_PIN_N) && hw_standby_pin_n_in;
    end
  end
endmodule
`default_nettype wire

// *** verif/smc_checker.sv ***
/*
  Checker for the standby mode controller, watching top-level ports only.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_checker (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Pins
  input wire logic reset_pin_n_in,
  input wire logic hw_standby_pin_n_in,
  // Power outputs
  input wire logic clk_en_out,
  input wire logic cpu_halt_out,
  input wire logic periph_reset_out,
  input wire logic cpu_reset_out,
  input wire logic port_hold_out,
  input wire logic port_float_out,
  input wire logic int_start_out,
  input wire logic osc_run_out
);
  // ****************
  // Settling span
  // ****************
  // The span keeps its value after the clock returns, so the wake pulse can be judged late.
  logic [19:0] span_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge clk_in) begin
    if (rst_in || !osc_run_out) begin
      span_q <= 20'h00000;
    end else if (!clk_en_out && span_q != 20'hFFFFF) begin
      span_q <= span_q + 20'h00001;
    end
  end
  sequence s_osc_wake;
    $rose(osc_run_out) && reset_pin_n_in && hw_standby_pin_n_in;
  endsequence
  property p_gate_late;
    s_osc_wake |-> !clk_en_out [*8];
  endproperty
  a_gate_late: assert property (p_gate_late)
    else $error("clock gated on too early");
  property p_int_span;
    int_start_out |-> span_q >= 20'h00400;
  endproperty
  a_int_span: assert property (p_int_span)
    else $error("wake before settling span");
  property p_int_pulse;
    int_start_out |=> !int_start_out;
  endproperty
  a_int_pulse: assert property (p_int_pulse)
    else $error("interrupt start longer than one cycle");
  property p_sw_quiet;
    port_hold_out |-> !clk_en_out && cpu_halt_out && periph_reset_out && !port_float_out;
  endproperty
  a_sw_quiet: assert property (p_sw_quiet)
    else $error("software standby outputs wrong");
  property p_hw_quiet;
    port_float_out |-> cpu_halt_out && periph_reset_out;
  endproperty
  a_hw_quiet: assert property (p_hw_quiet)
    else $error("hardware standby outputs wrong");
  property p_hw_entry;
    $fell(hw_standby_pin_n_in) |-> ##[1:3] port_float_out;
  endproperty
  a_hw_entry: assert property (p_hw_entry)
    else $error("standby pin low did not float ports");
  property p_hw_osc;
    port_float_out && hw_standby_pin_n_in |-> ##[1:3] osc_run_out;
  endproperty
  a_hw_osc: assert property (p_hw_osc)
    else $error("oscillator not restarted after standby pin");
  property p_res_osc;
    port_hold_out && !reset_pin_n_in && hw_standby_pin_n_in |-> ##[1:3] osc_run_out && cpu_reset_out;
  endproperty
  a_res_osc: assert property (p_res_osc)
    else $error("reset low in standby did not restart oscillator");
  property p_res_exit;
    cpu_reset_out && reset_pin_n_in && hw_standby_pin_n_in |-> ##[1:3] !cpu_reset_out;
  endproperty
  a_res_exit: assert property (p_res_exit)
    else $error("reset handling did not start");
endmodule
bind smc_top smc_checker smc_checker_i (.clk_in(clk_in), .rst_in(rst_in),
  .reset_pin_n_in(reset_pin_n_in), .hw_standby_pin_n_in(hw_standby_pin_n_in),
  .clk_en_out(clk_en_out), .cpu_halt_out(cpu_halt_out), .periph_reset_out(periph_reset_out),
  .cpu_reset_out(cpu_reset_out), .port_hold_out(port_hold_out),
  .port_float_out(port_float_out), .int_start_out(int_start_out), .osc_run_out(osc_run_out));
`default_nettype wire

// *** verif/smc_pin_model.sv ***
/*
  Model of the system logic driving the reset, standby and interrupt pins.
  Assumes the bench calls its tasks from its main process.
*/
`timescale 1ns/1ps
`default_nettype none
module smc_pin_model (
  // Clock
  input wire logic clk_in,
  // Pins into the controller
  output logic reset_pin_n_out,
  output logic hw_standby_pin_n_out,
  output logic nmi_pin_n_out,
  output logic [7:0] irq_out,
  output logic [15:0] key_out
);
  initial begin
    reset_pin_n_out = 1'b1;
    hw_standby_pin_n_out = 1'b1;
    nmi_pin_n_out = 1'b1;
    irq_out = 8'h00;
    key_out = 16'hFFFF;
  end
  // Source 8 sets the edge pin level, 9 pulls one key line, others raise that line.
  task automatic fire(input int src, input logic lvl, input int key);
    @(posedge clk_in);
    if (src == 8) begin
      nmi_pin_n_out <= lvl;
    end else if (src == 9) begin
      key_out[key] <= 1'b0;
    end else begin
      irq_out[src] <= 1'b1;
    end
  endtask
  task automatic quiet();
    @(posedge clk_in);
    irq_out <= 8'h00;
    key_out <= 16'hFFFF;
    nmi_pin_n_out <= 1'b1;
  endtask
  task automatic res_pulse(input int settle);
    @(posedge clk_in);
    reset_pin_n_out <= 1'b0;
    repeat (settle) @(posedge clk_in);
    reset_pin_n_out <= 1'b1;
  endtask
  // mode pins stay strapped outside; this model never moves them.
  // reset first, standby released before reset
  task automatic hw_cycle(input int settle);
    @(posedge clk_in);
    reset_pin_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    hw_standby_pin_n_out <= 1'b0;
    repeat (8) @(posedge clk_in);
    hw_standby_pin_n_out <= 1'b1;
    repeat (settle) @(posedge clk_in);
    reset_pin_n_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
/*
  Self-checking bench for the standby mode controller.
  Assumes the pin model and the bound checker are compiled beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic cpu_halt_in = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] reg_rdata_out, irq;
  logic [15:0] keys;
  logic res_n, hw_standby_pin_n_n, nmi_n, clk_en_out, cpu_halt_out, periph_reset_out, cpu_reset_out;
  logic port_hold_out, port_float_out, int_start_out, osc_run_out;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int num_checks = 0;
  always #20 clk_in = ~clk_in;
  smc_top smc_top_i (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .cpu_halt_in(cpu_halt_in), .reset_pin_n_in(res_n),
    .hw_standby_pin_n_in(hw_standby_pin_n_n), .nmi_pin_n_in(nmi_n), .irq_in(irq),
    .key_input_lines_in(keys), .clk_en_out(clk_en_out), .cpu_halt_out(cpu_halt_out),
    .periph_reset_out(periph_reset_out), .cpu_reset_out(cpu_reset_out),
    .port_hold_out(port_hold_out), .port_float_out(port_float_out),
    .int_start_out(int_start_out), .osc_run_out(osc_run_out));
  smc_pin_model smc_pin_model_i (.clk_in(clk_in), .reset_pin_n_out(res_n),
    .hw_standby_pin_n_out(hw_standby_pin_n_n), .nmi_pin_n_out(nmi_n), .irq_out(irq), .key_out(keys));
  task automatic chk_reg(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value reg_rdata_out exp %h got %h", exp, got);
    end
  endtask
  task automatic chk_pin(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s exp %b got %b", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
  endtask
  task automatic halt();
    @(posedge clk_in);
    cpu_halt_in <= 1'b1;
    @(posedge clk_in);
    cpu_halt_in <= 1'b0;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic wait_int(input int lo);
    int n;
    n = 0;
    while (int_start_out !== 1'b1 && n < lo + 100) begin
      @(negedge clk_in);
      n++;
    end
    chk_pin("int_start_out", 1'b1, int_start_out);
    chk_pin("settle_wait", 1'b1, n >= lo && n <= lo + 8);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    if (rd_q) begin
      chk_reg(exp_q.pop_front(), reg_rdata_out);
    end
    rd_q <= reg_rd_in;
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    num_errors++;
    print_verdict();
  end
  initial begin
    int key;
    int src;
    int lo;
    logic [7:0] ctl;
    void'($urandom(32));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(smc_pkg::SMC_ADDR_SYSCTRL, 8'h09);
    rd(smc_pkg::SMC_ADDR_INTEN, 8'h00);
    rd(4'hF, 8'h00);
    wr(smc_pkg::SMC_ADDR_INTEN, 8'h47);
    $display("test reset values done");
    // Sources: edge pin falling, edge pin rising, lines 0 to 2, one random key line,
    // line 6, then the edge pin again with the shortest crystal code.
    // the bench stands for an external clock, so no 8 ms bound applies.
    for (int s = 0; s < 8; s++) begin
      key = $urandom % 16;
      ctl = (s == 1) ? 8'hD5 : (s == 7) ? 8'h81 : 8'hD1;
      lo = (s == 7) ? int'(smc_pkg::SMC_SETTLE_0) : int'(smc_pkg::SMC_SETTLE_5);
      src = (s < 2 || s == 7) ? 8 : (s == 5) ? 9 : (s == 6) ? 6 : s - 2;
      if (s == 1) smc_pin_model_i.fire(8, 1'b0, 0);
      wr(smc_pkg::SMC_ADDR_SYSCTRL, ctl);
      halt();
      chk_pin("port_hold_out", 1'b1, port_hold_out);
      chk_pin("clk_en_out", 1'b0, clk_en_out);
      smc_pin_model_i.fire(src, s == 1, key);
      wait_int(lo);
      smc_pin_model_i.quiet();
      repeat (3) @(posedge clk_in);
      rd(smc_pkg::SMC_ADDR_SYSCTRL, ctl | 8'h08);
      wr(smc_pkg::SMC_ADDR_SYSCTRL, ctl & 8'h8F);
    end
    $display("test interrupt wake done");
    halt();
    smc_pin_model_i.fire(3, 1'b1, 0);
    repeat (20) @(negedge clk_in);
    chk_pin("port_hold_out", 1'b1, port_hold_out);
    smc_pin_model_i.quiet();
    fork
      smc_pin_model_i.res_pulse(40);
      begin
        repeat (10) @(negedge clk_in);
        chk_pin("osc_run_out", 1'b1, osc_run_out);
        chk_pin("cpu_reset_out", 1'b1, cpu_reset_out);
      end
    join
    repeat (5) @(negedge clk_in);
    chk_pin("cpu_reset_out", 1'b0, cpu_reset_out);
    $display("test reset wake done");
    for (int h = 0; h < 2; h++) begin
      wr(smc_pkg::SMC_ADDR_SYSCTRL, 8'hD0);
      if (h == 0) halt();
      fork
        smc_pin_model_i.hw_cycle(40);
        begin
          repeat (10) @(negedge clk_in);
          chk_pin("port_float_out", 1'b1, port_float_out);
        end
      join
      repeat (5) @(negedge clk_in);
      chk_pin("clk_en_out", 1'b1, clk_en_out);
      rd(smc_pkg::SMC_ADDR_SYSCTRL, 8'h09);
    end
    $display("test hardware standby done");
    wr(smc_pkg::SMC_ADDR_SYSCTRL, 8'h51);
    halt();
    chk_pin("port_hold_out", 1'b0, port_hold_out);
    chk_pin("clk_en_out", 1'b1, clk_en_out);
    rd(smc_pkg::SMC_ADDR_SYSCTRL, 8'h59);
    $display("test select clear done");
    repeat (3) @(posedge clk_in);
    print_verdict();
  end
endmodule
`default_nettype wire
